// ===== design/express_slot_pkg.sv
// constants and carrier types for the slot and link tuning registers
package express_slot_pkg;

  // ----------------------------------------------------------------
  // register offsets (byte addresses in configuration space)
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_SLOT_CAP = 8'hc4;
  localparam logic [7:0] OFS_SLOT_CTL = 8'hc8;
  localparam logic [7:0] OFS_CFG0 = 8'hcc;
  localparam logic [7:0] OFS_CFG1 = 8'hd0;
  localparam logic [7:0] OFS_CFG2 = 8'hd4;

  // ----------------------------------------------------------------
  // writable masks and values after reset
  // ----------------------------------------------------------------
  localparam logic [31:0] CTL_WMASK = 32'h0000_07ff;
  localparam logic [31:0] CTL_RST = 32'h0000_0000;
  localparam logic [31:0] CFG0_WMASK = 32'hffff_1fff;
  localparam logic [31:0] CFG0_RST = 32'h0400_1060;
  localparam logic [31:0] CFG1_WMASK = 32'hffff_03ff;
  localparam logic [31:0] CFG1_RST = 32'h0000_0000;
  localparam logic [31:0] CFG2_WMASK = 32'hff7f_7fff;
  localparam logic [31:0] CFG2_RST = 32'h0019_0254;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam logic [31:0] CAP_HP_MASK = 32'h0000_005d;
  localparam int HP_INT_EN_BIT = 5;
  localparam int STAT_EVT_LSB = 16;
  localparam int STAT_LATCH_BIT = 21;
  localparam int STAT_PRES_BIT = 22;
  localparam int STAT_CLR_LANE = 2;
  localparam logic [4:0] STAT_RST = 5'h00;

  // ----------------------------------------------------------------
  // idle-to-l1 waiting period decode
  // ----------------------------------------------------------------
  localparam logic [7:0] WAIT_WRAP = 8'h80;
  localparam logic [8:0] WAIT_BASE_MS = 9'h080;

  // ----------------------------------------------------------------
  // fast training ordered set symbols
  // ----------------------------------------------------------------
  localparam logic [7:0] K28_5 = 8'hbc;
  localparam logic [7:0] K28_1 = 8'h3c;
  localparam logic [1:0] FTS_LAST_IDX = 2'h3;

  typedef struct packed {
    logic valid;
    logic write;
    logic [7:0] addr;
    logic [3:0] be;
    logic [31:0] wdata;
  } cfg_req_t;

  typedef struct packed {
    logic k;
    logic [7:0] code;
  } sym_t;

  typedef struct packed {
    logic presence_changed;
    logic latch_changed;
    logic cmd_done;
    logic power_fault;
    logic button;
  } slot_evt_t;

  typedef struct packed {
    logic [4:0] link_mode_en;
    logic [2:0] lane_neg_tries;
    logic [4:0] ts1_count;
    logic [15:0] l1_enter_timer;
    logic [9:0] l0s_lifetime;
    logic [15:0] l1_lifetime;
    logic [7:0] cdr_fts;
    logic [6:0] l0s_exit_lat;
    logic [6:0] l1_exit_lat;
  } tuning_t;

endpackage

// ===== design/express_slot_regs.sv
// slot capability/control/status and link tuning register bank
`timescale 1ns/1ns
// ------------------------------------------------------------------
// Summary of operation
// R1: strap-enabled hot-plug sets five capability bits
// R2: waiting period decodes 0-127 +128ms, else -128
// R3: each fast training set: K28.5 then three K28.1
// R4: recovery time in sets, bits 7:0, reset 54h
// R5: l1 entry timer default bits 31:16, reset 0400h
// R6: lane negotiation tries, 3 bits, reset 3h
// R7: exit latencies, l1 19h, standby 2h
// R8: slot control bit 5 gates slot interrupts
// R9: hardware sets slot events, a status-lane read clears them
// ------------------------------------------------------------------
module express_slot_regs (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic hotplug_strap,
  input express_slot_pkg::cfg_req_t cfg_req,
  output logic cfg_ack,
  output logic [31:0] cfg_rdata,
  input express_slot_pkg::slot_evt_t slot_evt,
  input wire logic latch_state,
  input wire logic presence_state,
  output logic slot_irq,
  output logic [15:0] slot_ctrl,
  output express_slot_pkg::tuning_t tuning,
  output logic [8:0] l1_wait_ms,
  input wire logic fts_start,
  output logic fts_valid,
  output express_slot_pkg::sym_t fts_sym,
  output logic fts_done
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef enum {FTS_IDLE, FTS_SEND} fts_state_t;

  logic hp_en_reg;
  logic [31:0] ctl_reg;
  logic [31:0] cfg0_reg;
  logic [31:0] cfg1_reg;
  logic [31:0] cfg2_reg;
  logic [4:0] stat_reg;
  logic [4:0] stat_next;
  logic latch_reg;
  logic pres_reg;
  logic cfg_ack_reg;
  logic [31:0] cfg_rdata_reg;
  logic slot_irq_reg;
  logic [8:0] wait_ms_reg;
  fts_state_t fts_state_reg;
  logic [7:0] sets_left_reg;
  logic [1:0] sym_idx_reg;
  logic fts_valid_reg;
  express_slot_pkg::sym_t fts_sym_reg;
  logic fts_done_reg;
  logic [31:0] cap_word;
  logic [31:0] read_word;
  logic wr_hit;
  logic stat_rd_clear;
  logic [7:0] wait_field;
  logic [4:0] evt_bits;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // byte enables expand to a bit mask; only writable bits change
  function automatic logic [31:0] wr_merge(
    input logic [31:0] old_val,
    input logic [31:0] wdata,
    input logic [3:0] be,
    input logic [31:0] wmask
  );
    logic [31:0] m;
    m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}} & wmask;
    return (old_val & ~m) | (wdata & m);
  endfunction

  function automatic logic [8:0] wait_decode(input logic [7:0] v);
    if (v < express_slot_pkg::WAIT_WRAP) begin
      return express_slot_pkg::WAIT_BASE_MS + {1'b0, v};
    end
    return {1'b0, v - express_slot_pkg::WAIT_WRAP};
  endfunction

  // ----------------------------------------------------------------
  // strap capture
  // ----------------------------------------------------------------
  // strap is sampled while reset is held and frozen afterwards
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      hp_en_reg <= hotplug_strap;
    end
  end

  // capability bits follow the captured strap; the rest read zero
  assign cap_word = hp_en_reg ? express_slot_pkg::CAP_HP_MASK
                              : 32'h0000_0000; // R1

  assign wr_hit = cfg_req.valid && cfg_req.write;

  // ----------------------------------------------------------------
  // writable registers
  // ----------------------------------------------------------------
  // slot control, hot-plug interrupt enable included
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      ctl_reg <= express_slot_pkg::CTL_RST; // R8
    end else if (wr_hit
                 && cfg_req.addr == express_slot_pkg::OFS_SLOT_CTL) begin
      ctl_reg <= wr_merge(ctl_reg, cfg_req.wdata, cfg_req.be,
                          express_slot_pkg::CTL_WMASK); // R8
    end
  end

  // training config zero: lane tries and l1 entry timer
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      cfg0_reg <= express_slot_pkg::CFG0_RST; // R5 R6
    end else if (wr_hit && cfg_req.addr == express_slot_pkg::OFS_CFG0) begin
      cfg0_reg <= wr_merge(cfg0_reg, cfg_req.wdata, cfg_req.be,
                           express_slot_pkg::CFG0_WMASK); // R5 R6
    end
  end

  // lifetime timers
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      cfg1_reg <= express_slot_pkg::CFG1_RST;
    end else if (wr_hit && cfg_req.addr == express_slot_pkg::OFS_CFG1) begin
      cfg1_reg <= wr_merge(cfg1_reg, cfg_req.wdata, cfg_req.be,
                           express_slot_pkg::CFG1_WMASK);
    end
  end

  // recovery time, exit latencies and the waiting period share a word
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      cfg2_reg <= express_slot_pkg::CFG2_RST; // R4 R7 R2
    end else if (wr_hit && cfg_req.addr == express_slot_pkg::OFS_CFG2) begin
      cfg2_reg <= wr_merge(cfg2_reg, cfg_req.wdata, cfg_req.be,
                           express_slot_pkg::CFG2_WMASK); // R4 R7
    end
  end

  // ----------------------------------------------------------------
  // slot status
  // ----------------------------------------------------------------
  // a read touching the status lane clears the events it returned
  assign stat_rd_clear = cfg_req.valid && !cfg_req.write
    && cfg_req.addr == express_slot_pkg::OFS_SLOT_CTL
    && cfg_req.be[express_slot_pkg::STAT_CLR_LANE];

  // set wins over clear so an event in the read cycle is kept
  // input struct packing differs from the status and enable bit order,
  // so events are reordered here: button, fault, latch, presence, done
  always_comb begin
    evt_bits = {slot_evt.cmd_done, slot_evt.presence_changed,
                slot_evt.latch_changed, slot_evt.power_fault, slot_evt.button};
    stat_next = stat_reg;
    if (stat_rd_clear) begin
      stat_next = 5'h00;
    end
    stat_next = stat_next | evt_bits; // R9
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      stat_reg <= express_slot_pkg::STAT_RST;
      latch_reg <= 1'b0;
      pres_reg <= 1'b0;
    end else begin
      stat_reg <= stat_next; // R9
      latch_reg <= latch_state;
      pres_reg <= presence_state;
    end
  end

  // per-event enables in bits 4:0 pair with the status events
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      slot_irq_reg <= 1'b0;
    end else begin
      slot_irq_reg <= ctl_reg[express_slot_pkg::HP_INT_EN_BIT]
                      && |(stat_reg & ctl_reg[4:0]); // R8
    end
  end

  // ----------------------------------------------------------------
  // read path
  // ----------------------------------------------------------------
  always_comb begin
    read_word = 32'h0000_0000;
    case (cfg_req.addr)
      express_slot_pkg::OFS_SLOT_CAP: read_word = cap_word;
      express_slot_pkg::OFS_SLOT_CTL: begin
        read_word = ctl_reg;
        read_word[express_slot_pkg::STAT_EVT_LSB +: 5] = stat_reg; // R9
        read_word[express_slot_pkg::STAT_LATCH_BIT] = latch_reg;
        read_word[express_slot_pkg::STAT_PRES_BIT] = pres_reg;
      end
      express_slot_pkg::OFS_CFG0: read_word = cfg0_reg;
      express_slot_pkg::OFS_CFG1: read_word = cfg1_reg;
      express_slot_pkg::OFS_CFG2: read_word = cfg2_reg;
      default: read_word = 32'h0000_0000; // unmapped reads zero
    endcase
  end

  // every request is answered one cycle later, writes too
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      cfg_ack_reg <= 1'b0;
      cfg_rdata_reg <= 32'h0000_0000;
    end else begin
      cfg_ack_reg <= cfg_req.valid;
      if (cfg_req.valid && !cfg_req.write) begin
        cfg_rdata_reg <= read_word;
      end
    end
  end

  // ----------------------------------------------------------------
  // waiting period decode
  // ----------------------------------------------------------------
  assign wait_field = cfg2_reg[31:24];

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      wait_ms_reg <= express_slot_pkg::WAIT_BASE_MS;
    end else begin
      wait_ms_reg <= wait_decode(wait_field); // R2
    end
  end

  // ----------------------------------------------------------------
  // fast training ordered set sender
  // ----------------------------------------------------------------
  // sends cdr_fts sets; a start while busy is ignored
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      fts_state_reg <= FTS_IDLE;
      sets_left_reg <= 8'h00;
      sym_idx_reg <= 2'h0;
      fts_valid_reg <= 1'b0;
      fts_sym_reg <= '0;
      fts_done_reg <= 1'b0;
    end else begin
      fts_done_reg <= 1'b0;
      fts_valid_reg <= 1'b0;
      case (fts_state_reg)
        FTS_IDLE: begin
          if (fts_start) begin
            if (cfg2_reg[7:0] == 8'h00) begin
              fts_done_reg <= 1'b1; // nothing to send
            end else begin
              sets_left_reg <= cfg2_reg[7:0]; // R4
              sym_idx_reg <= 2'h0;
              fts_state_reg <= FTS_SEND;
            end
          end
        end
        FTS_SEND: begin
          fts_valid_reg <= 1'b1;
          fts_sym_reg.k <= 1'b1;
          fts_sym_reg.code <= (sym_idx_reg == 2'h0)
            ? express_slot_pkg::K28_5 : express_slot_pkg::K28_1; // R3
          sym_idx_reg <= sym_idx_reg + 2'h1;
          if (sym_idx_reg == express_slot_pkg::FTS_LAST_IDX) begin
            sets_left_reg <= sets_left_reg - 8'h01;
            if (sets_left_reg == 8'h01) begin
              fts_done_reg <= 1'b1;
              fts_state_reg <= FTS_IDLE;
            end
          end
        end
        default: fts_state_reg <= FTS_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign cfg_ack = cfg_ack_reg;
  assign cfg_rdata = cfg_rdata_reg;
  assign slot_irq = slot_irq_reg;
  assign slot_ctrl = ctl_reg[15:0];
  assign l1_wait_ms = wait_ms_reg;
  assign fts_valid = fts_valid_reg;
  assign fts_sym = fts_sym_reg;
  assign fts_done = fts_done_reg;

  // tuning fields straight from the register flops
  assign tuning.link_mode_en = cfg0_reg[4:0];
  assign tuning.lane_neg_tries = cfg0_reg[7:5]; // R6
  assign tuning.ts1_count = cfg0_reg[12:8];
  assign tuning.l1_enter_timer = cfg0_reg[31:16]; // R5
  assign tuning.l0s_lifetime = cfg1_reg[9:0];
  assign tuning.l1_lifetime = cfg1_reg[31:16];
  assign tuning.cdr_fts = cfg2_reg[7:0]; // R4
  assign tuning.l0s_exit_lat = cfg2_reg[14:8]; // R7
  assign tuning.l1_exit_lat = cfg2_reg[22:16]; // R7

endmodule

// ===== tb/express_slot_regs_sva.sv
// assertion checker for the slot and link tuning register bank
`timescale 1ns/1ns
module express_slot_regs_sva (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic hotplug_strap,
  input wire logic presence_state,
  input express_slot_pkg::cfg_req_t cfg_req,
  input wire logic [31:0] cfg_rdata,
  input express_slot_pkg::slot_evt_t slot_evt,
  input wire logic slot_irq,
  input wire logic [15:0] slot_ctrl,
  input express_slot_pkg::tuning_t tuning,
  input wire logic [8:0] l1_wait_ms,
  input wire logic fts_valid,
  input express_slot_pkg::sym_t fts_sym
);
  // ----------------------------------------------------------------
  // helpers and properties
  // ----------------------------------------------------------------
  logic strap_reg;
  // strap only counts while reset is held, same as the bank
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      strap_reg <= hotplug_strap;
    end
  end
  function automatic logic [8:0] dec(input logic [7:0] v);
    return v[7] ? {2'b00, v[6:0]} : 9'h080 + {1'b0, v};
  endfunction
  default clocking @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  property p_cap;
    cfg_req.valid && !cfg_req.write && cfg_req.addr == 8'hc4 |=>
      (cfg_rdata & 32'h5d) == (strap_reg ? 32'h5d : 32'h0);
  endproperty
  a_cap: assert property (p_cap) else $error("cap bits wrong");
  property p_wait;
    cfg_req.valid && cfg_req.write && cfg_req.addr == 8'hd4 &&
      cfg_req.be[3] ##1 !cfg_req.valid |=>
      l1_wait_ms == dec($past(cfg_req.wdata[31:24], 2));
  endproperty
  a_wait: assert property (p_wait) else $error("wait decode");
  property p_fts;
    fts_valid && fts_sym.k && fts_sym.code == 8'hbc |=>
      (fts_valid && fts_sym.code == 8'h3c)[*3];
  endproperty
  a_fts: assert property (p_fts) else $error("fts order");
  property p_cdr;
    $fell(sys_rst) |-> tuning.cdr_fts == 8'h54;
  endproperty
  a_cdr: assert property (p_cdr) else $error("cdr reset");
  property p_l1tmr;
    $fell(sys_rst) |-> tuning.l1_enter_timer == 16'h0400;
  endproperty
  a_l1tmr: assert property (p_l1tmr) else $error("timer reset");
  property p_tries;
    $fell(sys_rst) |-> tuning.lane_neg_tries == 3'h3;
  endproperty
  a_tries: assert property (p_tries) else $error("tries reset");
  property p_lat;
    $fell(sys_rst) |-> tuning.l1_exit_lat == 7'h19 &&
      tuning.l0s_exit_lat == 7'h02;
  endproperty
  a_lat: assert property (p_lat) else $error("latency reset");
  property p_irq_on;
    slot_evt.button && slot_ctrl[5] && slot_ctrl[0] ##1
      slot_ctrl[5] && slot_ctrl[0] |=> slot_irq;
  endproperty
  a_irq_on: assert property (p_irq_on) else $error("irq missing");
  property p_irq_off;
    !slot_ctrl[5] |=> !slot_irq;
  endproperty
  a_irq_off: assert property (p_irq_off) else $error("irq leak");
  property p_pres;
    cfg_req.valid && !cfg_req.write && cfg_req.addr == 8'hc8 &&
      $stable(presence_state) |=> cfg_rdata[22] == $past(presence_state);
  endproperty
  a_pres: assert property (p_pres) else $error("presence bit");
endmodule
bind express_slot_regs express_slot_regs_sva chk_u (.ref_clk(ref_clk),
  .sys_rst(sys_rst), .hotplug_strap(hotplug_strap),
  .presence_state(presence_state), .cfg_req(cfg_req),
  .cfg_rdata(cfg_rdata), .slot_evt(slot_evt), .slot_irq(slot_irq),
  .slot_ctrl(slot_ctrl), .tuning(tuning), .l1_wait_ms(l1_wait_ms),
  .fts_valid(fts_valid), .fts_sym(fts_sym));

// ===== tb/cfg_host.sv
// configuration host model driving the bank's request port
`timescale 1ns/1ns
module cfg_host (
  input wire logic ref_clk,
  input wire logic cfg_ack,
  input wire logic [31:0] cfg_rdata,
  output express_slot_pkg::cfg_req_t cfg_req
);
  // ----------------------------------------------------------------
  // one request per call, answer taken at the acknowledging edge
  // ----------------------------------------------------------------
  initial begin
    cfg_req = '0;
  end
  task automatic xfer(input logic w, input logic [7:0] a,
    input logic [3:0] b, input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge ref_clk);
    cfg_req <= '{1'b1, w, a, b, d};
    @(posedge ref_clk);
    // inverted leftovers so stale data can never pass for valid
    cfg_req <= '{1'b0, ~w, ~a, ~b, ~d};
    while (cfg_ack !== 1'b1 && n < 4) begin
      @(posedge ref_clk);
      n++;
    end
    q = (cfg_ack === 1'b1) ? cfg_rdata : 32'hxxxx_xxxx;
  endtask
endmodule

// ===== tb/express_slot_and_link_tuning_regs_bench.sv
// self-checking bench for the slot and link tuning register bank
`timescale 1ns/1ns
module express_slot_and_link_tuning_regs_bench;
  logic ref_clk, sys_rst, hotplug_strap, latch_state, presence_state;
  logic cfg_ack, slot_irq, fts_start, fts_valid, fts_done;
  logic [31:0] cfg_rdata, q, d;
  logic [15:0] slot_ctrl;
  logic [8:0] l1_wait_ms;
  logic [3:0] b;
  express_slot_pkg::cfg_req_t cfg_req;
  express_slot_pkg::slot_evt_t slot_evt;
  express_slot_pkg::tuning_t tuning;
  express_slot_pkg::sym_t fts_sym;
  int err_count, compares, seed, n, j;
  logic [7:0] ofs [5] = '{8'hc8, 8'hcc, 8'hd0, 8'hd4, 8'hc0};
  logic [31:0] mir [5] = '{32'h0, 32'h0400_1060, 32'h0, 32'h0019_0254, 32'h0};
  logic [31:0] wm [5] = '{32'h7ff, 32'hffff_1fff, 32'hffff_03ff,
    32'hff7f_7fff, 32'h0};
  int evt_pos [5] = '{16, 17, 20, 18, 19};
  logic [7:0] cv [4] = '{8'h00, 8'h01, 8'h80, 8'hff};
  // ----------------------------------------------------------------
  // design, host model, clock and helpers
  // ----------------------------------------------------------------
  express_slot_regs dut_u (.ref_clk(ref_clk), .sys_rst(sys_rst),
    .hotplug_strap(hotplug_strap), .cfg_req(cfg_req), .cfg_ack(cfg_ack),
    .cfg_rdata(cfg_rdata), .slot_evt(slot_evt), .latch_state(latch_state),
    .presence_state(presence_state), .slot_irq(slot_irq),
    .slot_ctrl(slot_ctrl), .tuning(tuning), .l1_wait_ms(l1_wait_ms),
    .fts_start(fts_start), .fts_valid(fts_valid), .fts_sym(fts_sym),
    .fts_done(fts_done));
  cfg_host host_u (.ref_clk(ref_clk), .cfg_ack(cfg_ack),
    .cfg_rdata(cfg_rdata), .cfg_req(cfg_req));
  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end
  function automatic logic [31:0] exp_wait(input logic [7:0] v);
    return v < 8'h80 ? 32'h80 + v : {24'h0, v - 8'h80};
  endfunction
  function automatic logic [31:0] bm(input logic [3:0] e);
    return {{8{e[3]}}, {8{e[2]}}, {8{e[1]}}, {8{e[0]}}};
  endfunction
  task automatic chk(input string nm, input logic [31:0] e,
    input logic [31:0] g);
    compares++;
    if (g !== e) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    host_u.xfer(1'b0, a, 4'hf, 32'h0, q);
    chk("rdata", e, q);
  endtask
  task automatic pulse(input int k);
    @(posedge ref_clk);
    slot_evt <= 5'h01 << k;
    @(posedge ref_clk);
    slot_evt <= 5'h00;
  endtask
  task automatic print_verdict;
    $display("compares %0d err_count %0d", compares, err_count);
    if (err_count == 0 && compares > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // watchdog: the whole sequence needs well under 1500 cycles
  initial begin
    repeat (3000) @(posedge ref_clk);
    err_count++;
    print_verdict();
  end
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    seed = 37;
    sys_rst = 1'b1;
    hotplug_strap = 1'b1;
    latch_state = 1'b0;
    presence_state = 1'b0;
    slot_evt = 5'h00;
    fts_start = 1'b0;
    repeat (4) @(posedge ref_clk);
    sys_rst <= 1'b0;
    rd(8'hc4, 32'h5d);
    for (int i = 0; i < 5; i++) rd(ofs[i], mir[i]);
    for (int i = 0; i < 30; i++) begin
      j = i % 5;
      d = $random(seed);
      b = (i < 10) ? 4'hf : 4'($random(seed));
      if (j == 3 && i < 20) d[31:24] = cv[i / 5];
      if (j == 3 && i < 20) b[3] = 1'b1;
      host_u.xfer(1'b1, ofs[j], b, d, q);
      mir[j] = (mir[j] & ~(wm[j] & bm(b))) | (d & wm[j] & bm(b));
      rd(ofs[j], mir[j]);
      chk("wait_ms", exp_wait(mir[3][31:24]), 32'(l1_wait_ms));
    end
    chk("tune_cfg0", mir[1], {tuning.l1_enter_timer, 3'h0, tuning.ts1_count,
      tuning.lane_neg_tries, tuning.link_mode_en});
    chk("tune_cfg1", mir[2], {tuning.l1_lifetime, 6'h0, tuning.l0s_lifetime});
    chk("tune_cfg2", mir[3] & 32'h00ff_ffff, {8'h0, 1'b0, tuning.l1_exit_lat,
      1'b0, tuning.l0s_exit_lat, tuning.cdr_fts});
    host_u.xfer(1'b1, 8'hc4, 4'hf, $random(seed), q);
    rd(8'hc4, 32'h5d);
    presence_state <= 1'b1;
    latch_state <= 1'b1;
    host_u.xfer(1'b1, 8'hc8, 4'h3, 32'h3f, q);
    chk("slot_ctrl", 32'h3f, {16'h0, slot_ctrl});
    for (int k = 0; k < 5; k++) begin
      pulse(k);
      repeat (2) @(posedge ref_clk);
      chk("irq_on", 32'h1, {31'h0, slot_irq});
      rd(8'hc8, 32'h0060_003f | (32'h1 << evt_pos[k]));
      repeat (2) @(posedge ref_clk);
      chk("irq_off", 32'h0, {31'h0, slot_irq});
    end
    host_u.xfer(1'b1, 8'hc8, 4'h3, 32'h1f, q);
    pulse(0);
    repeat (3) @(posedge ref_clk);
    chk("irq_masked", 32'h0, {31'h0, slot_irq});
    rd(8'hc8, 32'h0061_001f);
    host_u.xfer(1'b1, 8'hc8, 4'hc, 32'h007f_0000, q);
    rd(8'hc8, 32'h0060_001f);
    host_u.xfer(1'b1, 8'hd4, 4'h1, 32'h2, q);
    fts_start <= 1'b1;
    @(posedge ref_clk);
    fts_start <= 1'b0;
    n = 0;
    repeat (14) begin
      @(posedge ref_clk);
      if (fts_valid === 1'b1) begin
        chk("fts_sym", {24'h1, n % 4 ? 8'h3c : 8'hbc}, 32'(fts_sym));
        chk("fts_done", {31'h0, n == 7}, {31'h0, fts_done});
        n++;
      end
    end
    chk("fts_count", 32'h8, 32'(n));
    sys_rst <= 1'b1;
    hotplug_strap <= 1'b0;
    repeat (4) @(posedge ref_clk);
    sys_rst <= 1'b0;
    chk("tune_a", 32'h0054_1903, {tuning.cdr_fts, 1'b0, tuning.l1_exit_lat,
      5'h0, tuning.lane_neg_tries} & 32'hffff_ff07);
    chk("tune_b", 32'h0400_0002, {tuning.l1_enter_timer, 9'h0,
      tuning.l0s_exit_lat});
    chk("wait_rst", 32'h80, 32'(l1_wait_ms));
    rd(8'hc4, 32'h0);
    print_verdict();
  end
endmodule
